// ---- design/iccp_pkg.sv ----
// Function
// - Divide clock into four non-overlapping phases
// - Program counter increments at phase one
// - Fetch program word at phase four, into latch at phase one
// - Latch holds word; execute phases two-four
// - Operand read phase two, write-back phase four
// - Fetch overlaps execute: one word per cycle
// - Branches flush prefetched word, take two cycles
// - Page-select bit extends jump target beyond 512
// - File-select pointer bits choose data bank
// - Quarter-rate clock out in RC/internal modes
// - Master-clear mode forces pin pull-up on
// - Software pull-ups and wake on pin change
// - Ten-bit counter wraps, reset starts at zero
package iccp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W   = 12;             // APB address bits decoded
  localparam int PC_W     = 10;             // Program counter width
  localparam int IW       = 12;             // Instruction word width
  localparam int DW       = 8;              // Data register width
  localparam int RF_AW    = 7;              // Register file address width
  localparam int NPINS    = 6;              // Port pins with pull-up and wake
  localparam int MASTER_CLEAR_INPUT_PIN = 3;              // Pin shared with master clear

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] CTRL_OFF   = 12'h000;
  localparam logic [ADDR_W-1:0] FSR_OFF    = 12'h004;
  localparam logic [ADDR_W-1:0] PULLUP_OFF = 12'h008;
  localparam logic [ADDR_W-1:0] STAT_OFF   = 12'h00C;
  localparam logic [ADDR_W-1:0] WAKE_OFF   = 12'h010;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RUN_BIT   = 0;        // Core runs when set
  localparam int CTRL_SLEEP_BIT = 1;        // Core sleeps when set
  localparam int CTRL_PAGE_BIT  = 2;        // Program page select
  localparam int CTRL_MASTER_CLEAR_INPUT_BIT  = 3;        // Shared pin is master clear
  localparam int CTRL_OSC_LSB   = 4;        // Two-bit oscillator mode
  localparam int PU_WAKE_LSB    = 8;        // Wake enables in PULLUP
  localparam int ST_PHASE_LSB   = 10;       // Phase code in STAT
  localparam int ST_IW_LSB      = 12;       // Instruction latch in STAT
  localparam int ST_VALID_BIT   = 24;       // Execute stage holds a word

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DW-1:0]    FSR_RST  = 8'h80;
  localparam logic [PC_W-1:0]  PC_RST   = 10'h000;
  localparam logic [NPINS-1:0] PINS_RST = 6'h00;

  // ****************************************
  // Oscillator modes and opcodes
  // ****************************************
  localparam logic [1:0] OSC_XTAL      = 2'h0;
  localparam logic [1:0] OSC_EXT_RC    = 2'h1;
  localparam logic [1:0] OSC_INTERNAL  = 2'h2;
  localparam logic [2:0] JUMP_OPC      = 3'h5;   // Top three bits of a jump
  localparam logic [1:0] FILE_OPC      = 2'h0;   // Top two bits of a file op
  localparam logic [4:0] INDIRECT_F    = 5'h00;  // File address that goes indirect
  localparam int         CLK_DIV       = 4;      // Oscillator cycles per instruction

  // Phase codes, Gray along the cycle
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } iccp_phase_t;

endpackage

// ---- design/iccp_phase_if.sv ----
`timescale 1ns/1ps
// Phase strobes between the phase generator and the pipeline
interface iccp_phase_if;
  import iccp_pkg::*;
  logic        run;          // Advance the phase counter
  logic        restart;      // Force back to phase one
  iccp_phase_t phase;        // Current phase code
  logic        phase_one;    // Active in phase one while running
  logic        phase_two;    // Active in phase two while running
  logic        phase_three;  // Active in phase three while running
  logic        phase_four;   // Active in phase four while running
  logic        quarter_clk;  // Clock at a quarter of pclk

  modport gen  (input run, restart,
                output phase, phase_one, phase_two, phase_three, phase_four, quarter_clk);
  modport core (output run, restart,
                input phase, phase_one, phase_two, phase_three, phase_four, quarter_clk);
endinterface

// ---- design/iccp_phase_gen.sv ----
`timescale 1ns/1ps
// Four-phase generator: one instruction cycle is CLK_DIV pclk cycles
module iccp_phase_gen
  import iccp_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  iccp_phase_if.gen   ph
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    iccp_phase_t phase;    // Current phase
    logic        qclk;     // Quarter-rate clock level
  } iccp_gen_st_t;

  iccp_gen_st_t st_q;      // Registered state
  iccp_gen_st_t st_d;      // Next state

  // Step through the four phases in Gray order
  always_comb begin
    st_d = st_q;
    if (ph.restart) begin
      st_d.phase = PH_ONE;
    end else if (ph.run) begin
      unique case (st_q.phase)
        PH_ONE:   st_d.phase = PH_TWO;
        PH_TWO:   st_d.phase = PH_THREE;
        PH_THREE: st_d.phase = PH_FOUR;
        PH_FOUR:  st_d.phase = PH_ONE;
      endcase
    end
    // High over phases one and two, low over three and four
    st_d.qclk = (st_d.phase == PH_ONE) || (st_d.phase == PH_TWO);
  end

  // Register the state; reset lands in phase one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{phase: PH_ONE, qclk: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // Strobes only fire while running, so a halted core sees none
  assign ph.phase       = st_q.phase;
  assign ph.phase_one   = ph.run && !ph.restart && (st_q.phase == PH_ONE);
  assign ph.phase_two   = ph.run && !ph.restart && (st_q.phase == PH_TWO);
  assign ph.phase_three = ph.run && !ph.restart && (st_q.phase == PH_THREE);
  assign ph.phase_four  = ph.run && !ph.restart && (st_q.phase == PH_FOUR);
  assign ph.quarter_clk = st_q.qclk;

endmodule

// ---- design/iccp_core.sv ----
`timescale 1ns/1ps
// Fetch/execute pipeline with APB control registers and pin hooks
module iccp_core (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic [iccp_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Program memory, combinational read
  output logic      [iccp_pkg::PC_W-1:0]  prog_addr,
  input  wire logic [iccp_pkg::IW-1:0]    prog_data,
  // Data register file
  output logic      [iccp_pkg::RF_AW-1:0] rf_addr,
  output logic                            rf_rd_en,
  input  wire logic [iccp_pkg::DW-1:0]    rf_rdata,
  output logic                            rf_wr_en,
  output logic      [iccp_pkg::DW-1:0]    rf_wdata,
  // Execute hooks toward the ALU
  output logic      [iccp_pkg::IW-1:0]    exec_word,
  output logic      [iccp_pkg::DW-1:0]    exec_operand,
  input  wire logic [iccp_pkg::DW-1:0]    alu_result,
  // Pins
  input  wire logic [iccp_pkg::NPINS-1:0] port_pin_in,
  output logic      [iccp_pkg::NPINS-1:0] pullup_en,
  output logic                            quarter_clock_out,
  output logic                            quarter_clock_oe
);
  import iccp_pkg::*;

  // ****************************************
  // Phase generator
  // ****************************************
  iccp_phase_if ph ();                       // Phase strobes

  iccp_phase_gen u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .ph      (ph)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NPINS-1:0] sync1;        // First synchroniser stage
    logic [NPINS-1:0] sync2;        // Second synchroniser stage
    logic [NPINS-1:0] prev;         // Last settled pin levels
    logic             run;          // Software run enable
    logic             sleep;        // Sleeping, cleared by wake
    logic             page_sel;     // page_select_bit
    logic             master_clear_input_mode;    // Shared pin acts as master clear
    logic [1:0]       osc_mode;     // Oscillator mode
    logic [DW-1:0]    file_select_pointer;          // file_select_pointer
    logic [NPINS-1:0] pu;           // Software pull-up enables
    logic [NPINS-1:0] wake_en;      // Wake-on-change enables
    logic             wake_flag;    // Sticky wake event
    logic [PC_W-1:0]  pc;           // program_counter
    logic [PC_W-1:0]  fetch_addr;   // Address of the word being fetched
    logic [IW-1:0]    fetch_word;   // Prefetched word
    logic             fetch_valid;  // Prefetched word is usable
    logic [IW-1:0]    instr;        // instr_latch
    logic             exec_valid;   // instr_latch holds a real word
    logic [DW-1:0]    operand;      // Operand read in phase two
    logic [31:0]      rdata;        // Read data for the access phase
  } iccp_core_st_t;

  iccp_core_st_t st_q;              // Registered state
  iccp_core_st_t st_d;              // Next state

  // ****************************************
  // Decode helpers
  // ****************************************
  logic             master_clear_input_n; // Settled level of the shared pin
  logic             master_clear_input_hold;            // Master clear is asserted
  logic             is_jump;              // Executing word is a jump
  logic             is_file;              // Executing word touches a file
  logic             file_dest;            // Result goes back to the file
  logic [4:0]       file_f;               // File field of the word
  logic [RF_AW-1:0] file_addr;            // Banked file address
  logic [PC_W-1:0]  jump_target;          // Paged jump destination
  logic [NPINS-1:0] pin_change;           // Enabled pins that moved
  logic             setup;                // APB setup phase
  logic             access_wr;            // APB write taking effect
  logic             addr_hit;             // Address maps to a register
  logic [31:0]      rd_mux;               // Read data selected by address

  assign master_clear_input_n = st_q.sync2[MASTER_CLEAR_INPUT_PIN];
  // Held in reset while the pin is low in master-clear mode
  assign master_clear_input_hold = st_q.master_clear_input_mode && !master_clear_input_n;

  assign is_jump   = st_q.exec_valid && (st_q.instr[IW-1:IW-3] == JUMP_OPC);
  assign is_file   = st_q.exec_valid && (st_q.instr[IW-1:IW-2] == FILE_OPC);
  assign file_dest = st_q.instr[5];
  assign file_f    = st_q.instr[4:0];

  // Jump target: nine address bits from the word, top bit from the page
  assign jump_target = {st_q.page_sel, st_q.instr[8:0]};

  // Indirect goes through the low seven pointer bits; the upper half of the
  // window is banked by pointer bits six and five
  always_comb begin
    if (file_f == INDIRECT_F) begin
      file_addr = st_q.file_select_pointer[RF_AW-1:0];
    end else if (file_f[4]) begin
      file_addr = {st_q.file_select_pointer[6:5], file_f};
    end else begin
      file_addr = {2'b00, file_f};
    end
  end

  // Only the second stage and the held copy feed change detection
  assign pin_change = (st_q.sync2 ^ st_q.prev) & st_q.wake_en;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;

  // Address decode and read multiplexer
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFF: begin
        rd_mux[CTRL_RUN_BIT]              = st_q.run;
        rd_mux[CTRL_SLEEP_BIT]            = st_q.sleep;
        rd_mux[CTRL_PAGE_BIT]             = st_q.page_sel;
        rd_mux[CTRL_MASTER_CLEAR_INPUT_BIT]             = st_q.master_clear_input_mode;
        rd_mux[CTRL_OSC_LSB +: 2]         = st_q.osc_mode;
      end
      FSR_OFF: begin
        rd_mux[DW-1:0]                    = st_q.file_select_pointer;
      end
      PULLUP_OFF: begin
        rd_mux[NPINS-1:0]                 = st_q.pu;
        rd_mux[PU_WAKE_LSB +: NPINS]      = st_q.wake_en;
      end
      STAT_OFF: begin
        // Live view of the pipeline
        rd_mux[PC_W-1:0]                  = st_q.pc;
        rd_mux[ST_PHASE_LSB +: 2]         = ph.phase;
        rd_mux[ST_IW_LSB +: IW]           = st_q.instr;
        rd_mux[ST_VALID_BIT]              = st_q.exec_valid;
      end
      WAKE_OFF: begin
        rd_mux[0]                         = st_q.wake_flag;
      end
      default: begin
        // Unmapped: read zero, flag an error
        addr_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d = st_q;

    // Pin synchronisers and change history
    st_d.sync1 = port_pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.sync2;

    // Read data is captured in setup so it is stable in access
    if (setup) begin
      st_d.rdata = rd_mux;
    end

    // Register writes take effect in the access cycle
    if (access_wr) begin
      unique case (paddr)
        CTRL_OFF: begin
          st_d.run       = pwdata[CTRL_RUN_BIT];
          st_d.sleep     = pwdata[CTRL_SLEEP_BIT];
          st_d.page_sel  = pwdata[CTRL_PAGE_BIT];
          st_d.master_clear_input_mode = pwdata[CTRL_MASTER_CLEAR_INPUT_BIT];
          st_d.osc_mode  = pwdata[CTRL_OSC_LSB +: 2];
        end
        FSR_OFF: begin
          st_d.file_select_pointer = pwdata[DW-1:0];
        end
        PULLUP_OFF: begin
          st_d.pu      = pwdata[NPINS-1:0];
          st_d.wake_en = pwdata[PU_WAKE_LSB +: NPINS];
        end
        WAKE_OFF: begin
          // Write one to clear
          if (pwdata[0]) begin
            st_d.wake_flag = 1'b0;
          end
        end
        default: begin
          // Read-only or unmapped: nothing stored
        end
      endcase
    end

    // A pin change during sleep wakes the core; it wins over a clear
    if (st_q.sleep && (|pin_change)) begin
      st_d.wake_flag = 1'b1;
      st_d.sleep     = 1'b0;
    end

    // Master clear empties the pipeline and restarts at zero
    if (master_clear_input_hold) begin
      st_d.pc          = PC_RST;
      st_d.fetch_addr  = PC_RST;
      st_d.fetch_valid = 1'b0;
      st_d.exec_valid  = 1'b0;
    end else begin
      // Phase one: the prefetched word moves to the latch while the
      // next fetch address is taken and the counter steps on
      if (ph.phase_one) begin
        st_d.instr      = st_q.fetch_word;
        st_d.exec_valid = st_q.fetch_valid;
        st_d.fetch_addr = st_q.pc;
        st_d.pc         = st_q.pc + 10'h001;
      end

      // Phase two: operand read for file instructions
      if (ph.phase_two && is_file) begin
        st_d.operand = rf_rdata;
      end

      // Phase four: fetch completes in parallel with execution
      if (ph.phase_four) begin
        st_d.fetch_word  = prog_data;
        st_d.fetch_valid = 1'b1;
        // A jump throws the just-fetched word away and redirects
        if (is_jump) begin
          st_d.fetch_valid = 1'b0;
          st_d.pc          = jump_target;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.sync1       <= PINS_RST;
      st_q.sync2       <= PINS_RST;
      st_q.prev        <= PINS_RST;
      st_q.run         <= 1'b1;
      st_q.sleep       <= 1'b0;
      st_q.page_sel    <= 1'b0;
      st_q.master_clear_input_mode   <= 1'b0;
      st_q.osc_mode    <= OSC_XTAL;
      st_q.file_select_pointer         <= FSR_RST;
      st_q.pu          <= PINS_RST;
      st_q.wake_en     <= PINS_RST;
      st_q.wake_flag   <= 1'b0;
      st_q.pc          <= PC_RST;
      st_q.fetch_addr  <= PC_RST;
      st_q.fetch_word  <= 12'h000;
      st_q.fetch_valid <= 1'b0;
      st_q.instr       <= 12'h000;
      st_q.exec_valid  <= 1'b0;
      st_q.operand     <= 8'h00;
      st_q.rdata       <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Phase control
  // ****************************************
  // Sleep stops the phases outright; the pins still watch for wake
  assign ph.run     = st_q.run && !st_q.sleep && !master_clear_input_hold;
  assign ph.restart = master_clear_input_hold;

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata  = st_q.rdata;
  assign pready  = 1'b1;                    // Zero wait states
  assign pslverr = psel && penable && !addr_hit;

  assign prog_addr = st_q.fetch_addr;

  // File strobes only during the matching phase of a file word
  assign rf_addr  = file_addr;
  assign rf_rd_en = ph.phase_two && is_file;
  assign rf_wr_en = ph.phase_four && is_file && file_dest;
  assign rf_wdata = alu_result;

  assign exec_word    = st_q.instr;
  assign exec_operand = st_q.operand;

  // Master-clear mode overrides the software pull-up on its pin
  always_comb begin
    pullup_en = st_q.pu;
    if (st_q.master_clear_input_mode) begin
      pullup_en[MASTER_CLEAR_INPUT_PIN] = 1'b1;
    end
  end

  // Quarter clock leaves the chip only in RC or internal modes
  assign quarter_clock_out = ph.quarter_clk;
  assign quarter_clock_oe  = (st_q.osc_mode == OSC_EXT_RC) ||
                             (st_q.osc_mode == OSC_INTERNAL);

endmodule

// ---- test/iccp_core_asserts.sv ----
`timescale 1ns/1ps
// ****
// Port checks of the pipeline core
// ****
module iccp_core_asserts (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic [iccp_pkg::ADDR_W-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 pwdata,
  input wire logic [iccp_pkg::PC_W-1:0]   prog_addr,
  input wire logic [iccp_pkg::RF_AW-1:0]  rf_addr,
  input wire logic                        rf_rd_en,
  input wire logic                        rf_wr_en,
  input wire logic [iccp_pkg::DW-1:0]     rf_wdata,
  input wire logic [iccp_pkg::IW-1:0]     exec_word,
  input wire logic [iccp_pkg::DW-1:0]     alu_result,
  input wire logic [iccp_pkg::NPINS-1:0]  pullup_en,
  input wire logic                        quarter_clock_out,
  input wire logic                        quarter_clock_oe
);
  import iccp_pkg::*;
  logic          wr_ok;   // APB write completing at this edge
  logic          mode_on; // Written mode drives the clock pin
  logic [DW-1:0] fsr_q;   // Shadow pointer, predicts the bank
  assign wr_ok   = psel && penable && pwrite;
  assign mode_on = pwdata[5:4] == OSC_EXT_RC || pwdata[5:4] == OSC_INTERNAL;
  // Shadow loads at the same edge as the core pointer, so the two never differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsr_q <= FSR_RST;
    end else if (wr_ok && paddr == FSR_OFF) begin
      fsr_q <= pwdata[DW-1:0];
    end
  end
  function automatic logic [RF_AW-1:0] iccp_bank(input logic [IW-1:0] w);
    if (w[4:0] == INDIRECT_F) return fsr_q[6:0];
    return w[4] ? {fsr_q[6:5], w[4:0]} : {2'b00, w[4:0]};
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Each level stands two cycles at least; sleep may stretch it, never cut it
  a_qclk_duty: assert property (
    $changed(quarter_clock_out) |=> $stable(quarter_clock_out))
    else $error("quarter clock level shorter than two cycles");
  // Updates land as phase one ends, so they are first seen in phase two
  a_fetch_step: assert property (
    $changed(prog_addr) |-> quarter_clock_out ##1 !quarter_clock_out)
    else $error("fetch address off phase");
  a_latch_step: assert property (
    $changed(exec_word) |-> quarter_clock_out ##1 !quarter_clock_out)
    else $error("latch moved off phase");
  a_rd_phase: assert property (
    rf_rd_en |-> quarter_clock_out && $past(quarter_clock_out) && exec_word[11:10] == FILE_OPC)
    else $error("operand read off phase two");
  a_wr_phase: assert property (
    rf_wr_en |-> !quarter_clock_out && !$past(quarter_clock_out) && exec_word[5] &&
    rf_wdata == alu_result) else $error("write-back off phase four");
  a_wr_follows: assert property (
    rf_wr_en |-> $past(rf_rd_en, 2)) else $error("write-back without operand read");
  a_rd_bank: assert property (
    rf_rd_en |-> rf_addr == iccp_bank(exec_word)) else $error("bank address wrong");
  a_oe_mode: assert property (
    wr_ok && paddr == CTRL_OFF |=> quarter_clock_oe == $past(mode_on))
    else $error("clock out enable wrong");
  a_master_clear_input_pull: assert property (
    wr_ok && paddr == CTRL_OFF && pwdata[CTRL_MASTER_CLEAR_INPUT_BIT] |=> pullup_en[MASTER_CLEAR_INPUT_PIN])
    else $error("master clear pull-up off");
  c_write: cover property (rf_wr_en);
  c_indirect: cover property (rf_rd_en && exec_word[4:0] == INDIRECT_F);
  c_oe: cover property ($rose(quarter_clock_oe));
endmodule
bind iccp_core iccp_core_asserts i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prog_addr(prog_addr),
  .rf_addr(rf_addr), .rf_rd_en(rf_rd_en), .rf_wr_en(rf_wr_en), .rf_wdata(rf_wdata),
  .exec_word(exec_word), .alu_result(alu_result), .pullup_en(pullup_en),
  .quarter_clock_out(quarter_clock_out), .quarter_clock_oe(quarter_clock_oe));

// ---- test/iccp_mem_model.sv ----
`timescale 1ns/1ps
// ****
// Program memory and data register file
// ****
module iccp_mem_model (
  input  wire logic                       pclk,
  input  wire logic [iccp_pkg::PC_W-1:0]  prog_addr,
  output logic      [iccp_pkg::IW-1:0]    prog_data,
  input  wire logic [iccp_pkg::RF_AW-1:0] rf_addr,
  input  wire logic                       rf_rd_en,
  output logic      [iccp_pkg::DW-1:0]    rf_rdata,
  input  wire logic                       rf_wr_en,
  input  wire logic [iccp_pkg::DW-1:0]    rf_wdata
);
  import iccp_pkg::*;
  logic [IW-1:0] rom [2**PC_W];  // Program words, loaded by the bench
  logic [DW-1:0] ram [2**RF_AW]; // Data registers
  logic [DW-1:0] last_q = '0;    // Last byte driven on the read bus
  assign prog_data = rom[prog_addr];
  // Idle read bus shows the inverse, so a stray sample cannot match
  assign rf_rdata = rf_rd_en ? ram[rf_addr] : ~last_q;
  always @(posedge pclk) begin
    if (rf_rd_en) begin
      last_q <= ram[rf_addr];
    end
    if (rf_wr_en) begin
      ram[rf_addr] <= rf_wdata;
    end
  end
endmodule

// ---- test/iccp_core_tb.sv ----
`timescale 1ns/1ps
module iccp_core_tb;
  import iccp_pkg::*;
  // ****
  // Signals
  // ****
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, r;
  logic [PC_W-1:0]   prog_addr;
  logic [IW-1:0]     prog_data, exec_word;
  logic [RF_AW-1:0]  rf_addr;
  logic              rf_rd_en, rf_wr_en, qco, qoe, e;
  logic [DW-1:0]     rf_rdata, rf_wdata, exec_operand, alu_result;
  logic [NPINS-1:0]  port_pin_in, pullup_en;
  int                error_cnt, checked;
  iccp_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .rf_addr(rf_addr),
    .rf_rd_en(rf_rd_en), .rf_rdata(rf_rdata), .rf_wr_en(rf_wr_en), .rf_wdata(rf_wdata),
    .exec_word(exec_word), .exec_operand(exec_operand), .alu_result(alu_result),
    .port_pin_in(port_pin_in), .pullup_en(pullup_en), .quarter_clock_out(qco),
    .quarter_clock_oe(qoe));
  iccp_mem_model i_mem (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data),
    .rf_addr(rf_addr), .rf_rd_en(rf_rd_en), .rf_rdata(rf_rdata), .rf_wr_en(rf_wr_en),
    .rf_wdata(rf_wdata));
  // Toy ALU so write-back data is traceable to the operand
  always @(posedge pclk) begin
    alu_result <= exec_operand ^ 8'h5A;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; request held until the edge that samples pready high
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  // Bounded wait for a fetch address, then judged
  task automatic wait_pc(input logic [PC_W-1:0] a, input int lim);
    for (int n = 0; n < lim && prog_addr !== a; n++) @(negedge pclk);
    chk("prog_addr", a, prog_addr);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_fetch();
    logic [PC_W-1:0] ea [8] = '{0, 1, 2, 3, 'h10, 'h11, 'h10, 'h11};
    @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      chk("prog_addr", ea[i], prog_addr);
      if (i inside {[1:3]}) chk("exec_word", i_mem.rom[i-1], exec_word);
      // Fetch address moves as phase one ends, so look in phase two
      @(posedge qco);
      repeat (2) @(negedge pclk);
    end
    chk("ram5", 8'h69, i_mem.ram[5]);
    $display("t_fetch done");
  endtask
  task automatic t_regs();
    apb(CTRL_OFF, 1'b0, 0);
    chk("ctrl", 32'h1, r);
    apb(FSR_OFF, 1'b0, 0);
    chk("fsr", 32'h80, r);
    apb(FSR_OFF, 1'b1, 32'hE5);
    apb(FSR_OFF, 1'b0, 0);
    chk("fsr", 32'hE5, r);
    apb(12'h020, 1'b0, 0);
    chk("unmapped", 0, r);
    chk("pslverr", 1, e);
    $display("t_regs done");
  endtask
  task automatic t_page();
    apb(CTRL_OFF, 1'b1, 32'h5);
    wait_pc(10'h210, 100);
    wait_pc(10'h3FF, 3000);
    @(posedge qco);
    repeat (2) @(negedge pclk);
    chk("prog_addr", 0, prog_addr);
    repeat (12) @(negedge pclk);
    chk("ram70", 8'h55, i_mem.ram[7'h70]);
    $display("t_page done");
  endtask
  task automatic t_pins();
    apb(PULLUP_OFF, 1'b1, 32'h115);
    chk("pullup_en", 6'h15, pullup_en);
    apb(CTRL_OFF, 1'b1, 32'hD);
    chk("pullup_en", 6'h1D, pullup_en);
    // Sleep lands as phase one begins, so no strobe pair is split
    @(posedge qco);
    @(posedge pclk);
    apb(CTRL_OFF, 1'b1, 32'hF);
    @(posedge pclk);
    port_pin_in <= 6'h09;
    repeat (8) @(posedge pclk);
    apb(WAKE_OFF, 1'b0, 0);
    chk("wake", 32'h1, r);
    apb(CTRL_OFF, 1'b0, 0);
    chk("ctrl", 32'hD, r);
    apb(WAKE_OFF, 1'b1, 32'h1);
    apb(WAKE_OFF, 1'b0, 0);
    chk("wake", 32'h0, r);
    $display("t_pins done");
  endtask
  task automatic t_clk();
    int hi;
    for (int m = 0; m < 4; m++) begin
      apb(CTRL_OFF, 1'b1, (m << 4) | 5);
      chk("oe", m == 1 || m == 2, qoe);
      hi = 0;
      repeat (8) @(negedge pclk) hi += (qco === 1'b1);
      chk("qclk_high", 4, hi);
    end
    $display("t_clk done");
  endtask
  task automatic end_of_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****
  // Clock, watchdog and main sequence
  // ****
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #250000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    port_pin_in = 6'h08;
    foreach (i_mem.rom[i]) i_mem.rom[i] = 12'hFFF;
    foreach (i_mem.ram[i]) i_mem.ram[i] = 8'h00;
    {i_mem.rom[0], i_mem.rom[1], i_mem.rom[2]} = {12'h025, 12'h000, 12'hA10};
    {i_mem.rom['h10], i_mem.rom['h211]} = {12'hA10, 12'h030};
    {i_mem.ram[5], i_mem.ram['h70]} = {8'h33, 8'h0F};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_fetch();
    t_regs();
    t_page();
    t_pins();
    t_clk();
    end_of_test();
  end
endmodule
